// [lecch_regs.svh]
// register offsets, field positions, reset values and counts for the hold config bank
`ifndef LECCH_REGS_SVH
`define LECCH_REGS_SVH
// ==========================================
// register offsets on the configuration port
`define LECCH_LANE3_OFS 12'h48B
`define LECCH_LANE4_OFS 12'h48C
`define LECCH_LANE5_OFS 12'h48D
// ==========================================
// field layout
`define LECCH_FIELD_MSB 2
`define LECCH_FIELD_LSB 0
`define LECCH_CTRL_BIT 2
`define LECCH_TABLE_BIT 1
`define LECCH_DISP_BIT 0
// ==========================================
// reset values and counts
`define LECCH_HOLD_RST 3'h7
`define LECCH_RSVD_VAL 5'h00
`define LECCH_TERM_CNT 8'hFF
`define LECCH_CNT_ZERO 8'h00
`define LECCH_CNT_ONE 8'h01
`define LECCH_RD_ZERO 8'h00
`endif

// [lecch_pkg.sv]
// types shared by the hold config bank and its counters
package lecch_pkg;
  // error counter value
  typedef logic [7:0] lecch_cnt_t;
  // register data byte
  typedef logic [7:0] lecch_byte_t;
  // register address
  typedef logic [11:0] lecch_addr_t;
  // error classes, ordered as their field bits
  typedef enum logic [1:0] {
    lecch_bad_disparity_error,
    lecch_not_in_table_error,
    lecch_unexpected_control_char_error
  } lecch_class_e;
endpackage

// [lecch_err_counter.sv]
// one lane error counter with saturate or wrap and a sticky terminal flag
`timescale 1ns/1ps
`include "lecch_regs.svh"
module lecch_err_counter
  import lecch_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_sync_b,
  input wire logic ce,
  input wire logic clr,
  input wire logic inc,
  input wire logic hold,
  output lecch_cnt_t count_ff,
  output logic reached_ff
);
  // ==========================================
  // counter next state
  lecch_cnt_t nxt_count;
  logic nxt_reached;

  // count events, saturate or wrap, sticky flag
  always_comb begin
    nxt_count = count_ff;
    if (clr) begin
      // an event in the clear cycle is still counted
      nxt_count = inc ? `LECCH_CNT_ONE : `LECCH_CNT_ZERO;
    end else if (inc) begin
      if (hold && (count_ff == `LECCH_TERM_CNT)) begin
        nxt_count = count_ff;
      end else begin
        nxt_count = count_ff + `LECCH_CNT_ONE;
      end
    end
    // flag follows the value the counter takes
    nxt_reached = (clr ? 1'b0 : reached_ff) || (nxt_count == `LECCH_TERM_CNT);
  end

  // ==========================================
  // state registers
  always_ff @(posedge mclk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      count_ff <= `LECCH_CNT_ZERO;
      reached_ff <= 1'b0;
    end else if (ce) begin
      count_ff <= nxt_count;
      reached_ff <= nxt_reached;
    end
  end

  // ==========================================
  // checks
  property p_hold_sat;
    @(posedge mclk) disable iff (!rst_sync_b)
      (ce && hold && !clr && count_ff == `LECCH_TERM_CNT) |=> (count_ff == `LECCH_TERM_CNT);
  endproperty
  a_hold_sat: assert property (p_hold_sat) else $error("held counter left terminal value");

  property p_wrap;
    @(posedge mclk) disable iff (!rst_sync_b)
      (ce && inc && !hold && !clr && count_ff == `LECCH_TERM_CNT) |=> (count_ff == `LECCH_CNT_ZERO);
  endproperty
  a_wrap: assert property (p_wrap) else $error("free counter did not wrap to zero");

  property p_inc;
    @(posedge mclk) disable iff (!rst_sync_b)
      (ce && inc && !clr && count_ff != `LECCH_TERM_CNT) |=> (count_ff == $past(count_ff) + 8'h01);
  endproperty
  a_inc: assert property (p_inc) else $error("counter did not step by one");

  property p_reached;
    @(posedge mclk) disable iff (!rst_sync_b)
      (count_ff == `LECCH_TERM_CNT) |-> reached_ff;
  endproperty
  a_reached: assert property (p_reached) else $error("terminal flag low at terminal value");

  property p_reached_sticky;
    @(posedge mclk) disable iff (!rst_sync_b)
      (reached_ff && !clr) |=> reached_ff;
  endproperty
  a_reached_sticky: assert property (p_reached_sticky) else $error("terminal flag dropped");

  c_saturate: cover property (@(posedge mclk) disable iff (!rst_sync_b)
    hold && inc && count_ff == `LECCH_TERM_CNT ##1 count_ff == `LECCH_TERM_CNT);
  c_wrap: cover property (@(posedge mclk) disable iff (!rst_sync_b)
    !hold && inc && ce && count_ff == `LECCH_TERM_CNT ##1 count_ff == `LECCH_CNT_ZERO);
  c_clear_inc: cover property (@(posedge mclk) disable iff (!rst_sync_b) ce && clr && inc);
endmodule

// [lecch_top.sv]
// lane 3 to 5 error counter hold configuration with the counters it steers
// Overview of operation
// - three-bit hold field, resets 0x7, rest zero
// - hold set: counter stops at 0xFF
// - hold clear: counter wraps to zero
// - bit2 control char, bit1 table, bit0 disparity
// - sticky terminal flag once counter hits 0xFF
`timescale 1ns/1ps
`include "lecch_regs.svh"
module lecch_top
  import lecch_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic ce,
  input wire lecch_addr_t reg_addr,
  input wire lecch_byte_t reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output lecch_byte_t reg_rdata_ff,
  input wire logic deframer_soft_reset,
  input wire logic [8:0] err_event,
  input wire logic [8:0] err_count_clear,
  output logic [71:0] err_count,
  output logic [8:0] terminal_reached_flags
);
  // ==========================================
  // reset release
  logic [1:0] rst_sync_ff; // two-stage release chain
  logic rst_sync_b; // synchronised reset for the bank

  // release the reset through two flops; the chain freezes with the rest while ce is low
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rst_sync_ff <= 2'h0;
    end else if (ce) begin
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
  end
  // only the second flop feeds the design
  assign rst_sync_b = rst_sync_ff[1];

  // ==========================================
  // hold configuration registers
  logic [2:0] hold_cfg_ff [3]; // one field per lane, lane 3 first
  logic [2:0] nxt_hold_cfg [3];
  lecch_byte_t nxt_rdata;

  // decode writes and reads on the configuration port
  always_comb begin
    // default: keep every field and the last read data
    for (int i = 0; i < 3; i++) begin
      nxt_hold_cfg[i] = hold_cfg_ff[i];
    end
    nxt_rdata = reg_rdata_ff;
    // writes land whatever the soft reset state; software keeps the ordering
    if (reg_wr) begin
      if (reg_addr == `LECCH_LANE3_OFS) begin
        nxt_hold_cfg[0] = reg_wdata[`LECCH_FIELD_MSB:`LECCH_FIELD_LSB];
      end else if (reg_addr == `LECCH_LANE4_OFS) begin
        nxt_hold_cfg[1] = reg_wdata[`LECCH_FIELD_MSB:`LECCH_FIELD_LSB];
      end else if (reg_addr == `LECCH_LANE5_OFS) begin
        nxt_hold_cfg[2] = reg_wdata[`LECCH_FIELD_MSB:`LECCH_FIELD_LSB];
      end
    end
    if (reg_rd) begin
      // reserved bits read as zero, unmapped reads return zero
      if (reg_addr == `LECCH_LANE3_OFS) begin
        nxt_rdata = {`LECCH_RSVD_VAL, hold_cfg_ff[0]};
      end else if (reg_addr == `LECCH_LANE4_OFS) begin
        nxt_rdata = {`LECCH_RSVD_VAL, hold_cfg_ff[1]};
      end else if (reg_addr == `LECCH_LANE5_OFS) begin
        nxt_rdata = {`LECCH_RSVD_VAL, hold_cfg_ff[2]};
      end else begin
        nxt_rdata = `LECCH_RD_ZERO;
      end
    end
  end

  // register the bank and the read data
  always_ff @(posedge mclk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      // reset loads every field with its hold-all value
      for (int i = 0; i < 3; i++) begin
        hold_cfg_ff[i] <= `LECCH_HOLD_RST;
      end
      reg_rdata_ff <= `LECCH_RD_ZERO;
    end else if (ce) begin
      for (int i = 0; i < 3; i++) begin
        hold_cfg_ff[i] <= nxt_hold_cfg[i];
      end
      reg_rdata_ff <= nxt_rdata;
    end
  end

  // ==========================================
  // error counters, three lanes by three classes
  genvar g;
  generate
    for (g = 0; g < 9; g++) begin : g_cnt
      // index is lane*3 + class, class equal to its field bit
      lecch_err_counter u_cnt (
        .mclk(mclk),
        .rst_sync_b(rst_sync_b),
        .ce(ce),
        // soft reset acts as a clear on every counter
        .clr(err_count_clear[g] || deframer_soft_reset),
        // events are dropped while the deframer sits in soft reset
        .inc(err_event[g] && !deframer_soft_reset),
        .hold(hold_cfg_ff[g / 3][g % 3]),
        .count_ff(err_count[g*8 +: 8]),
        .reached_ff(terminal_reached_flags[g])
      );
    end
  endgenerate

  // ==========================================
  // checks
  property p_reset_value;
    @(posedge mclk) disable iff (!rst_b)
      $rose(rst_sync_b) |-> (hold_cfg_ff[0] == `LECCH_HOLD_RST
        && hold_cfg_ff[1] == `LECCH_HOLD_RST
        && hold_cfg_ff[2] == `LECCH_HOLD_RST);
  endproperty
  a_reset_value: assert property (p_reset_value) else $error("hold field reset not 0x7");

  property p_rsvd_zero;
    @(posedge mclk) disable iff (!rst_sync_b)
      (ce && reg_rd) |=> (reg_rdata_ff[7:3] == 5'h00);
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved read bits not zero");

  property p_write_lane4;
    @(posedge mclk) disable iff (!rst_sync_b)
      (ce && reg_wr && reg_addr == `LECCH_LANE4_OFS)
        |=> (hold_cfg_ff[1] == $past(reg_wdata[2:0]));
  endproperty
  a_write_lane4: assert property (p_write_lane4) else $error("lane 4 field not written");

  property p_map_ctrl;
    @(posedge mclk) disable iff (!rst_sync_b)
      (ce && err_event[5] && !err_count_clear[5] && !deframer_soft_reset
        && err_count[47:40] == 8'hFF && hold_cfg_ff[1][2]) |=> (err_count[47:40] == 8'hFF);
  endproperty
  a_map_ctrl: assert property (p_map_ctrl) else $error("lane 4 bit 2 not steering ctrl counter");

  // ==========================================
  // register port checks

  // read data stands until the next accepted read
  property p_rdata_stands;
    @(posedge mclk) disable iff (!rst_sync_b)
      !(ce && reg_rd) |=> $stable(reg_rdata_ff);
  endproperty
  a_rdata_stands: assert property (p_rdata_stands)
    else $error("read data moved without a read");

  // a read of lane 3 returns the stored field over zero reserved bits
  property p_read_lane3;
    @(posedge mclk) disable iff (!rst_sync_b)
      (ce && reg_rd && reg_addr == `LECCH_LANE3_OFS)
        |=> (reg_rdata_ff == {`LECCH_RSVD_VAL, $past(hold_cfg_ff[0])});
  endproperty
  a_read_lane3: assert property (p_read_lane3)
    else $error("lane 3 read data wrong");

  // a read outside the bank returns zero
  property p_read_unmapped;
    @(posedge mclk) disable iff (!rst_sync_b)
      (ce && reg_rd && reg_addr != `LECCH_LANE3_OFS && reg_addr != `LECCH_LANE4_OFS
        && reg_addr != `LECCH_LANE5_OFS) |=> (reg_rdata_ff == `LECCH_RD_ZERO);
  endproperty
  a_read_unmapped: assert property (p_read_unmapped)
    else $error("unmapped read not zero");

  // clock enable low freezes every field
  property p_cfg_frozen;
    @(posedge mclk) disable iff (!rst_sync_b)
      !ce |=> ($stable(hold_cfg_ff[0]) && $stable(hold_cfg_ff[1]) && $stable(hold_cfg_ff[2]));
  endproperty
  a_cfg_frozen: assert property (p_cfg_frozen)
    else $error("field moved with clock enable low");

  // ==========================================
  // per-counter checks
  genvar k;
  generate
    for (k = 0; k < 9; k++) begin : g_chk
      // one event at terminal: held counters stay, free ones wrap, per field bit
      property p_map_class;
        @(posedge mclk) disable iff (!rst_sync_b)
          (ce && err_event[k] && !err_count_clear[k] && !deframer_soft_reset
            && err_count[k*8 +: 8] == `LECCH_TERM_CNT)
            |=> (err_count[k*8 +: 8] == ($past(hold_cfg_ff[k / 3][k % 3]) ? `LECCH_TERM_CNT
              : `LECCH_CNT_ZERO));
      endproperty
      a_map_class: assert property (p_map_class)
        else $error("field bit does not steer its own counter");

      // soft reset clears count and flag and swallows events
      property p_soft_clear;
        @(posedge mclk) disable iff (!rst_sync_b)
          (ce && deframer_soft_reset)
            |=> (err_count[k*8 +: 8] == `LECCH_CNT_ZERO && !terminal_reached_flags[k]);
      endproperty
      a_soft_clear: assert property (p_soft_clear)
        else $error("soft reset left a counter or flag set");

      // flag only rises together with the terminal value
      property p_flag_rise;
        @(posedge mclk) disable iff (!rst_sync_b)
          $rose(terminal_reached_flags[k]) |-> (err_count[k*8 +: 8] == `LECCH_TERM_CNT);
      endproperty
      a_flag_rise: assert property (p_flag_rise)
        else $error("terminal flag rose away from terminal value");
    end
  endgenerate

  c_cfg_write: cover property (@(posedge mclk) disable iff (!rst_sync_b)
    ce && reg_wr && reg_addr == `LECCH_LANE5_OFS && deframer_soft_reset);
  c_ce_freeze: cover property (@(posedge mclk) disable iff (!rst_sync_b)
    !ce && (|err_event));
endmodule

// [lecch_top_test.sv]
// self-checking bench for the lane 3 to 5 hold config bank and its counters
`timescale 1ns/1ps
`include "lecch_regs.svh"
module lecch_top_test;
  import lecch_pkg::*;
  // ==========================================
  // design connections
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  logic ce = 1'b1;
  lecch_addr_t reg_addr = 12'h000;
  lecch_byte_t reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  lecch_byte_t reg_rdata_ff;
  logic deframer_soft_reset = 1'b1;
  logic [8:0] err_event = 9'h000;
  logic [8:0] err_count_clear = 9'h000;
  logic [71:0] err_count;
  logic [8:0] terminal_reached_flags;
  // bench state and reference model
  int bad_count = 0;
  int compares = 0;
  int cyc = 0;
  integer seed = 32'hC9CE14A4;
  logic [2:0] hold [3];
  lecch_cnt_t cnt [9];
  logic [8:0] flag = 9'h000;
  lecch_top i_dut (.mclk(mclk), .rst_b(rst_b), .ce(ce), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff),
    .deframer_soft_reset(deframer_soft_reset), .err_event(err_event),
    .err_count_clear(err_count_clear), .err_count(err_count),
    .terminal_reached_flags(terminal_reached_flags));
  // ==========================================
  // clock and hang guard
  initial forever #5 mclk = ~mclk;
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      bad_count++;
      end_sim();
    end
  end
  // ==========================================
  // shared tasks
  task automatic check(input string what, input logic [71:0] seen, input logic [71:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %s exp %0h seen %0h", what, exp, seen);
    end
  endtask
  // one write strobe, driven on the falling edge
  task automatic reg_write(input lecch_addr_t a, input lecch_byte_t d);
    @(negedge mclk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge mclk);
    reg_wr = 1'b0;
  endtask
  // one read strobe, data taken once registered
  task automatic reg_check(input lecch_addr_t a, input lecch_byte_t exp);
    @(negedge mclk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge mclk);
    reg_rd = 1'b0;
    check("reg_rdata_ff", reg_rdata_ff, exp);
  endtask
  // drive one cycle of events and clears, stepping the model alongside
  task automatic step(input logic [8:0] ev, input logic [8:0] clr);
    @(negedge mclk);
    err_event = ev;
    err_count_clear = clr;
    for (int i = 0; i < 9; i++) begin
      if (clr[i]) begin
        cnt[i] = ev[i] ? 8'h01 : 8'h00;
        flag[i] = 1'b0;
      end else if (ev[i] && !(hold[i / 3][i % 3] && cnt[i] == 8'hFF)) begin
        cnt[i] = cnt[i] + 8'h01;
        if (cnt[i] == 8'hFF) flag[i] = 1'b1;
      end
    end
  endtask
  // quiet the inputs and compare every counter and flag
  task automatic check_counts(input string name);
    @(negedge mclk);
    err_event = 9'h000;
    err_count_clear = 9'h000;
    for (int i = 0; i < 9; i++) check("err_count", err_count[i * 8 +: 8], cnt[i]);
    check("terminal_reached_flags", terminal_reached_flags, flag);
    $display("test %s done", name);
  endtask
  task automatic end_sim();
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // ==========================================
  // main sequence
  initial begin
    foreach (cnt[i]) cnt[i] = 8'h00;
    repeat (2) @(negedge mclk);
    rst_b = 1'b1;
    repeat (4) @(negedge mclk);
    // reset values, reserved bits and an unmapped place
    for (int l = 0; l < 3; l++) reg_check(lecch_addr_t'(`LECCH_LANE3_OFS + l), 8'h07);
    reg_check(12'h48A, 8'h00);
    // fields set in soft reset: one random lane, one holding only its control char counter,
    // one all set
    for (int l = 0; l < 3; l++) begin
      hold[l] = (l == 0) ? 3'($random(seed)) : ((l == 1) ? 3'h4 : 3'h7);
      reg_write(lecch_addr_t'(`LECCH_LANE3_OFS + l), {5'h1F, hold[l]});
      reg_check(lecch_addr_t'(`LECCH_LANE3_OFS + l), {5'h00, hold[l]});
    end
    reg_write(12'h48E, 8'hFF);
    reg_check(12'h48E, 8'h00);
    $display("test registers done");
    @(negedge mclk);
    deframer_soft_reset = 1'b0;
    // count right up to terminal, then one past it
    repeat (255) step(9'h1FF, 9'h000);
    check_counts("terminal");
    step(9'h1FF, 9'h000);
    check_counts("hold_or_wrap");
    // random traffic with rare per-counter clears
    repeat (700) step(9'($random(seed)), ($random(seed) % 16 == 0) ? 9'($random(seed)) : 9'h0);
    check_counts("random");
    // clock enable low freezes counters, flags and read data
    @(negedge mclk);
    ce = 1'b0;
    err_event = 9'h1FF;
    err_count_clear = 9'h1C0;
    reg_check(`LECCH_LANE5_OFS, 8'h00);
    err_event = 9'h000;
    err_count_clear = 9'h000;
    ce = 1'b1;
    check_counts("clock_enable");
    // soft reset clears all and ignores events
    @(negedge mclk);
    deframer_soft_reset = 1'b1;
    err_event = 9'h1FF;
    foreach (cnt[i]) cnt[i] = 8'h00;
    flag = 9'h000;
    check_counts("soft_reset");
    // read and write in one cycle return the old field
    @(negedge mclk);
    reg_addr = `LECCH_LANE3_OFS;
    reg_wdata = 8'h00;
    reg_wr = 1'b1;
    reg_rd = 1'b1;
    @(negedge mclk);
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    check("reg_rdata_ff", reg_rdata_ff, {5'h00, hold[0]});
    reg_check(`LECCH_LANE3_OFS, 8'h00);
    $display("test read_write done");
    // reset in mid-run brings every field back to its hold-all value
    @(negedge mclk);
    rst_b = 1'b0;
    @(negedge mclk);
    rst_b = 1'b1;
    repeat (3) @(negedge mclk);
    for (int l = 0; l < 3; l++) reg_check(lecch_addr_t'(`LECCH_LANE3_OFS + l), 8'h07);
    $display("test mid_reset done");
    end_sim();
  end
endmodule
